// [common/tbd_pkg.sv]
package tbd_pkg;

  // Avalon-MM register byte offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DROPS = 4'h8;

  // Control register fields and reset values.
  localparam int CTRL_AFI_LSB = 0;
  localparam int CTRL_TUNNEL_BIT = 8;
  localparam logic [7:0] AFI_RESET = 8'h00;

  // Status register field positions.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CHAIN_BIT = 2;
  localparam int STAT_CMD_LSB = 8;

  // Layer-3 command codes.
  localparam logic [7:0] CMD_REQB = 8'h05;
  localparam logic [7:0] CMD_ATTRIB = 8'h1d;
  localparam logic [7:0] CMD_HLTB = 8'h50;

  // Request parameter byte: wake-up flag position.
  localparam int PARAM_WAKE_BIT = 3;

  // APDU instruction codes.
  localparam logic [7:0] INS_SELECT = 8'ha4;
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam logic [7:0] INS_READ = 8'hb0;
  localparam logic [7:0] INS_WRITE = 8'hd6;

  // Protocol control byte fields.
  localparam int PCB_CHAIN_BIT = 4;
  localparam int PCB_NAK_BIT = 4;
  localparam logic [1:0] PCB_IBLK = 2'b00;
  localparam logic [1:0] PCB_RBLK = 2'b10;
  localparam logic [1:0] PCB_SBLK = 2'b11;
  localparam logic [1:0] SBLK_DESEL = 2'b00;
  localparam logic [1:0] SBLK_WTX = 2'b11;

  // Second protocol byte of the request answer: 256 byte frames, type 1.
  localparam logic [7:0] ATQB_PROTO2 = 8'h81;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READY,
    ST_ACTIVE,
    ST_HALT
  } tbd_state_type;

  typedef enum logic [2:0] {
    RSP_NONE,
    RSP_ATQB,
    RSP_ATTRIB,
    RSP_RACK,
    RSP_RESEND,
    RSP_DESEL,
    RSP_WTX
  } tbd_rsp_type;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SELECT,
    OP_VERIFY,
    OP_READ,
    OP_WRITE,
    OP_OTHER
  } tbd_op_type;

endpackage

// [common/tbd_frame_if.sv]
`timescale 1ns/1ps
interface tbd_frame_if;
  logic done;
  logic bad;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] len;
  modport parser (output done, output bad, output b0, output b1, output b2, output len);
  modport dec (input done, input bad, input b0, input b1, input b2, input len);
endinterface

// [core/tbd_frame_parser.sv]
`timescale 1ns/1ps
module tbd_frame_parser
  import tbd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Received bytes.
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic rx_crc_ok,
  // Parsed frame.
  tbd_frame_if.parser fr
);

  logic [7:0] cnt_q, cnt_d;
  logic [7:0] b0_q, b0_d, b1_q, b1_d, b2_q, b2_d;
  logic done_q, done_d, bad_q, bad_d;
  logic [7:0] len_q, len_d;

  always_comb begin
    cnt_d = cnt_q;
    b0_d = b0_q;
    b1_d = b1_q;
    b2_d = b2_q;
    len_d = len_q;
    done_d = 1'b0;
    bad_d = 1'b0;
    if (rx_valid) begin
      if (cnt_q == 8'h00) begin
        b0_d = rx_byte;
        b1_d = 8'h00;
        b2_d = 8'h00;
      end else if (cnt_q == 8'h01) begin
        b1_d = rx_byte;
      end else if (cnt_q == 8'h02) begin
        b2_d = rx_byte;
      end
      if (rx_last) begin
        cnt_d = 8'h00;
        len_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
        done_d = rx_crc_ok;
        bad_d = !rx_crc_ok;
      end else if (cnt_q != 8'hff) begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      len_q <= 8'h00;
      done_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      b0_q <= b0_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      len_q <= len_d;
      done_q <= done_d;
      bad_q <= bad_d;
    end
  end

  assign fr.done = done_q;
  assign fr.bad = bad_q;
  assign fr.b0 = b0_q;
  assign fr.b1 = b1_q;
  assign fr.b2 = b2_q;
  assign fr.len = len_q;

endmodule

// [core/tbd_typeb_decoder.sv]
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tbd_typeb_decoder
  import tbd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Received frame bytes from the RF front end.
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic rx_crc_ok,
  // Answer requests to the transmitter.
  output logic rsp_valid,
  output tbd_rsp_type rsp_kind,
  output logic [7:0] atqb_proto2,
  // APDU dispatch.
  output logic apdu_valid,
  output tbd_op_type apdu_op,
  output logic apdu_host,
  output logic apdu_auth
);

  tbd_frame_if fr();

  tbd_frame_parser u_parser (
    .clk(clk),
    .nrst(nrst),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_last(rx_last),
    .rx_crc_ok(rx_crc_ok),
    .fr(fr)
  );

  function automatic logic afi_hit(input logic [7:0] rx, input logic [7:0] st);
    if (rx == 8'h00) begin
      return 1'b1;
    end else if (rx[3:0] == 4'h0) begin
      return rx[7:4] == st[7:4];
    end else if (rx[7:4] == 4'h0) begin
      return rx[3:0] == st[3:0];
    end else begin
      return rx == st;
    end
  endfunction

  function automatic tbd_op_type ins_op(input logic [7:0] ins);
    if (ins == INS_SELECT) begin
      return OP_SELECT;
    end else if (ins == INS_VERIFY) begin
      return OP_VERIFY;
    end else if (ins == INS_READ) begin
      return OP_READ;
    end else if (ins == INS_WRITE) begin
      return OP_WRITE;
    end else begin
      return OP_OTHER;
    end
  endfunction

  // Protocol state and answer logic.
  tbd_state_type state_q, state_d;
  logic chain_q, chain_d;
  logic [7:0] last_cmd_q, last_cmd_d;
  logic rsp_valid_q, rsp_valid_d;
  tbd_rsp_type rsp_kind_q, rsp_kind_d;
  logic apdu_valid_q, apdu_valid_d;
  tbd_op_type apdu_op_q, apdu_op_d;
  logic apdu_host_q, apdu_host_d;
  logic apdu_auth_q, apdu_auth_d;
  logic [7:0] afi_q, afi_d;
  logic tunnel_q, tunnel_d;
  logic [15:0] drops_q, drops_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic req_ok;

  // Request acceptance: the slot code and upper parameter bits play no part.
  assign req_ok = afi_hit(fr.b1, afi_q) && (state_q != ST_HALT || fr.b2[PARAM_WAKE_BIT]);

  always_comb begin
    state_d = state_q;
    chain_d = chain_q;
    last_cmd_d = last_cmd_q;
    rsp_valid_d = 1'b0;
    rsp_kind_d = rsp_kind_q;
    apdu_valid_d = 1'b0;
    apdu_op_d = apdu_op_q;
    apdu_host_d = apdu_host_q;
    apdu_auth_d = apdu_auth_q;
    if (fr.done) begin
      last_cmd_d = fr.b0;
      if (state_q == ST_ACTIVE) begin
        if (fr.b0[7:6] == PCB_IBLK) begin
          chain_d = fr.b0[PCB_CHAIN_BIT];
          if (!chain_q) begin
            apdu_valid_d = 1'b1;
            apdu_op_d = ins_op(fr.b2);
            apdu_auth_d = fr.b2 == INS_VERIFY;
            apdu_host_d = tunnel_q && (fr.b2 == INS_READ || fr.b2 == INS_WRITE);
          end
          if (fr.b0[PCB_CHAIN_BIT]) begin
            rsp_valid_d = 1'b1;
            rsp_kind_d = RSP_RACK;
          end
        end else if (fr.b0[7:6] == PCB_RBLK) begin
          rsp_valid_d = 1'b1;
          rsp_kind_d = fr.b0[PCB_NAK_BIT] ? RSP_RESEND : RSP_RACK;
        end else if (fr.b0[7:6] == PCB_SBLK && fr.b0[5:4] == SBLK_DESEL) begin
          rsp_valid_d = 1'b1;
          rsp_kind_d = RSP_DESEL;
          chain_d = 1'b0;
          state_d = ST_HALT;
        end else if (fr.b0[7:6] == PCB_SBLK && fr.b0[5:4] == SBLK_WTX) begin
          rsp_valid_d = 1'b1;
          rsp_kind_d = RSP_WTX;
        end
      end else if (fr.b0 == CMD_REQB) begin
        if (req_ok) begin
          rsp_valid_d = 1'b1;
          rsp_kind_d = RSP_ATQB;
          state_d = ST_READY;
        end
      end else if (fr.b0 == CMD_ATTRIB && state_q == ST_READY) begin
        rsp_valid_d = 1'b1;
        rsp_kind_d = RSP_ATTRIB;
        chain_d = 1'b0;
        state_d = ST_ACTIVE;
      end else if (fr.b0 == CMD_HLTB && state_q == ST_READY) begin
        rsp_valid_d = 1'b1;
        rsp_kind_d = RSP_NONE;
        state_d = ST_HALT;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      chain_q <= 1'b0;
      last_cmd_q <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_kind_q <= RSP_NONE;
      apdu_valid_q <= 1'b0;
      apdu_op_q <= OP_NONE;
      apdu_host_q <= 1'b0;
      apdu_auth_q <= 1'b0;
    end else begin
      state_q <= state_d;
      chain_q <= chain_d;
      last_cmd_q <= last_cmd_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_kind_q <= rsp_kind_d;
      apdu_valid_q <= apdu_valid_d;
      apdu_op_q <= apdu_op_d;
      apdu_host_q <= apdu_host_d;
      apdu_auth_q <= apdu_auth_d;
    end
  end

  // Register file: one wait cycle, then read data and write effect.
  always_comb begin
    afi_d = afi_q;
    tunnel_d = tunnel_q;
    drops_d = fr.bad ? drops_q + 16'h0001 : drops_q;
    rdata_d = rdata_q;
    wait_d = !((avs_read || avs_write) && wait_q);
    if (avs_read && wait_q) begin
      if (avs_address == REG_CTRL) begin
        rdata_d = {23'h000000, tunnel_q, afi_q};
      end else if (avs_address == REG_STATUS) begin
        rdata_d = {16'h0000, last_cmd_q, 5'h00, chain_q, state_q};
      end else if (avs_address == REG_DROPS) begin
        rdata_d = {16'h0000, drops_q};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
    if (avs_write && !wait_q) begin
      if (avs_address == REG_CTRL) begin
        afi_d = avs_writedata[CTRL_AFI_LSB +: 8];
        tunnel_d = avs_writedata[CTRL_TUNNEL_BIT];
      end else if (avs_address == REG_DROPS) begin
        drops_d = fr.bad ? 16'h0001 : 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      afi_q <= AFI_RESET;
      tunnel_q <= 1'b0;
      drops_q <= 16'h0000;
      rdata_q <= 32'h00000000;
      wait_q <= 1'b1;
    end else begin
      afi_q <= afi_d;
      tunnel_q <= tunnel_d;
      drops_q <= drops_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  // The protocol byte is a fixed flop so the output stays registered.
  logic [7:0] proto2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      proto2_q <= ATQB_PROTO2;
    end else begin
      proto2_q <= ATQB_PROTO2;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_kind = rsp_kind_q;
  assign atqb_proto2 = proto2_q;
  assign apdu_valid = apdu_valid_q;
  assign apdu_op = apdu_op_q;
  assign apdu_host = apdu_host_q;
  assign apdu_auth = apdu_auth_q;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_afi_zero: assert property (
    fr.done && fr.b0 == CMD_REQB && fr.b1 == 8'h00 && state_q != ST_HALT && state_q != ST_ACTIVE
    |=> rsp_valid_q && rsp_kind_q == RSP_ATQB && state_q == ST_READY)
    else $error("Zero identifier request not answered.");

  chk_afi_miss: assert property (
    fr.done && fr.b0 == CMD_REQB && state_q != ST_ACTIVE && !afi_hit(fr.b1, afi_q)
    |=> !rsp_valid_q)
    else $error("Mismatched identifier was answered.");

  chk_upper_nib: assert property (
    fr.done && fr.b0 == CMD_REQB && (state_q == ST_IDLE || state_q == ST_READY) && fr.b1[3:0] == 4'h0
    && fr.b1[7:4] != 4'h0
    |=> rsp_valid_q == ($past(fr.b1[7:4]) == $past(afi_q[7:4])))
    else $error("Upper nibble match answered wrongly.");

  chk_halt_plain: assert property (
    fr.done && fr.b0 == CMD_REQB && state_q == ST_HALT && !fr.b2[PARAM_WAKE_BIT]
    |=> !rsp_valid_q ##1 state_q == ST_HALT)
    else $error("Halted tag answered a plain request.");

  chk_attrib_act: assert property (
    fr.done && fr.b0 == CMD_ATTRIB && state_q == ST_READY
    |=> rsp_kind_q == RSP_ATTRIB && state_q == ST_ACTIVE && !chain_q)
    else $error("Attribute command did not activate.");

  chk_hltb_halt: assert property (
    fr.done && fr.b0 == CMD_HLTB && state_q == ST_READY |=> state_q == ST_HALT)
    else $error("Halt command ignored.");

  chk_crc_drop: assert property (
    fr.bad |=> !rsp_valid_q && !apdu_valid_q && $stable(state_q))
    else $error("Corrupt frame produced activity.");

  chk_read_route: assert property (
    fr.done && state_q == ST_ACTIVE && fr.b0[7:6] == PCB_IBLK && !chain_q && fr.b2 == INS_READ
    |=> apdu_valid_q && apdu_op_q == OP_READ && apdu_host_q == $past(tunnel_q))
    else $error("Read instruction routed wrongly.");

  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not one cycle after request.");

  chk_frame_size: assert property (
    $rose(nrst) ##1 1'b1 |-> atqb_proto2[7:4] == 4'h8)
    else $error("Frame size code wrong.");

  cov_wake: cover property (fr.done && fr.b0 == CMD_REQB && state_q == ST_HALT ##1 rsp_valid_q);
  cov_chain: cover property (rsp_valid_q && rsp_kind_q == RSP_RACK ##[1:50] apdu_valid_q);
  cov_desel: cover property (rsp_valid_q && rsp_kind_q == RSP_DESEL);

endmodule

// [verif/tbd_reader_model.sv]
`timescale 1ns/1ps
module tbd_reader_model (
  // Clock.
  input wire logic clk,
  // Frame bytes towards the tag.
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_last,
  output logic rx_crc_ok
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_last = 1'b0;
    rx_crc_ok = 1'b0;
  end

  // Sends up to three bytes with no card identifier or node address inserted.
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n,
                      input logic crc);
    logic [7:0] fb [3];
    fb = '{b0, b1, b2};
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_byte <= fb[i];
      rx_last <= (i == n - 1);
      rx_crc_ok <= crc & (i == n - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_crc_ok <= 1'b0;
    rx_byte <= ~fb[n - 1];
  endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import tbd_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_valid;
  logic rx_last;
  logic rx_crc_ok;
  logic [7:0] rx_byte;
  logic rsp_valid;
  logic apdu_valid;
  logic apdu_host;
  logic apdu_auth;
  tbd_rsp_type rsp_kind;
  tbd_op_type apdu_op;
  logic [7:0] atqb_proto2;
  int err_total = 0;
  int tests_run = 0;
  int rsp_n = 0;
  int apdu_n = 0;
  int a;
  logic [7:0] afi_s;
  logic [7:0] afi_q;
  logic [31:0] rd;
  logic [7:0] ins_tab [5] = '{8'ha4, 8'h20, 8'hb0, 8'hd6, 8'h84};

  always #10 clk = ~clk;

  tbd_typeb_decoder dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
    .rx_crc_ok(rx_crc_ok), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .atqb_proto2(atqb_proto2),
    .apdu_valid(apdu_valid), .apdu_op(apdu_op), .apdu_host(apdu_host), .apdu_auth(apdu_auth));

  tbd_reader_model rdr (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
    .rx_crc_ok(rx_crc_ok));

  always @(posedge clk) begin
    if (rsp_valid === 1'b1) rsp_n <= rsp_n + 1;
    if (apdu_valid === 1'b1) apdu_n <= apdu_n + 1;
  end

  function automatic logic afi_hit(input logic [7:0] s, input logic [7:0] q);
    if (q == 8'h00) return 1'b1;
    if (q[3:0] == 4'h0) return q[7:4] == s[7:4];
    if (q[7:4] == 4'h0) return q[3:0] == s[3:0];
    return q == s;
  endfunction

  function automatic tbd_op_type op_of(input logic [7:0] i);
    case (i)
      8'ha4: return OP_SELECT;
      8'h20: return OP_VERIFY;
      8'hb0: return OP_READ;
      8'hd6: return OP_WRITE;
      default: return OP_OTHER;
    endcase
  endfunction

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check(t < 20, "bus timeout");
  endtask

  task automatic st(input logic [1:0] s);
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd[1:0] === s, "state");
  endtask

  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n,
                       input logic crc, input logic ans, input tbd_rsp_type k);
    int r;
    r = rsp_n;
    rdr.send(b0, b1, b2, n, crc);
    repeat (4) @(posedge clk);
    check((rsp_n - r) === int'(ans), "answer count");
    if (ans) check(rsp_kind === k, "answer kind");
  endtask

  task automatic summarize;
    $display("errors %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize;
  end

  initial begin
    void'($urandom(32'hfed2));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(atqb_proto2 === 8'h81, "protocol byte");
    bus(1'b0, REG_CTRL, 32'h0);
    check(rd === 32'h0, "ctrl reset");
    st(2'd0);
    bus(1'b0, 4'hc, 32'h0);
    check(rd === 32'h0, "unmapped read");
    for (int i = 0; i < 42; i++) begin
      afi_s = 8'($urandom);
      afi_q = 8'($urandom);
      case (i % 6)
        0: afi_q = 8'h00;
        1: afi_q = {afi_s[7:4] ^ 4'(i % 4 / 2), 4'h0};
        2: afi_q = {4'h0, afi_s[3:0] ^ 4'(i % 4 / 2)};
        3: afi_q = afi_s ^ 8'(i % 4 / 2);
        default: ;
      endcase
      bus(1'b1, REG_CTRL, {24'h0, afi_s});
      bus(1'b0, REG_CTRL, 32'h0);
      check(rd === {24'h0, afi_s}, "ctrl readback");
      frame(8'h05, afi_q, 8'($urandom), 3, 1'b1, afi_hit(afi_s, afi_q), RSP_ATQB);
    end
    st(2'd1);
    frame(8'h50, 8'h00, 8'h00, 1, 1'b1, 1'b1, RSP_NONE);
    st(2'd3);
    frame(8'h05, 8'h00, 8'h00, 3, 1'b1, 1'b0, RSP_NONE);
    frame(8'h05, 8'h00, 8'hef, 3, 1'b1, 1'b1, RSP_ATQB);
    frame(8'h05, 8'h00, 8'h0d, 3, 1'b1, 1'b1, RSP_ATQB);
    frame(8'h1d, 8'h00, 8'h00, 1, 1'b0, 1'b0, RSP_NONE);
    bus(1'b0, REG_DROPS, 32'h0);
    check(rd === 32'h1, "drop count");
    st(2'd1);
    frame(8'h1d, 8'h00, 8'h00, 1, 1'b1, 1'b1, RSP_ATTRIB);
    st(2'd2);
    for (int t = 0; t < 2; t++) begin
      bus(1'b1, REG_CTRL, 32'(t) << 8);
      foreach (ins_tab[j]) begin
        a = apdu_n;
        frame(8'h02, 8'($urandom), ins_tab[j], 3, 1'b1, 1'b0, RSP_NONE);
        check(apdu_n === a + 1 && apdu_op === op_of(ins_tab[j]), "apdu op");
        check(apdu_auth === (ins_tab[j] == 8'h20), "apdu auth");
        if (ins_tab[j] inside {8'hb0, 8'hd6}) check(apdu_host === (t == 1), "apdu host");
      end
    end
    a = apdu_n;
    frame(8'h12, 8'h00, 8'hb0, 3, 1'b1, 1'b1, RSP_RACK);
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd[2] === 1'b1 && apdu_n === a + 1, "chain start");
    frame(8'h02, 8'h00, 8'hb0, 3, 1'b1, 1'b0, RSP_NONE);
    check(apdu_n === a + 1, "chain end");
    frame(8'ha2, 8'h00, 8'h00, 1, 1'b1, 1'b1, RSP_RACK);
    frame(8'hb2, 8'h00, 8'h00, 1, 1'b1, 1'b1, RSP_RESEND);
    frame(8'hf2, 8'h01, 8'h00, 2, 1'b1, 1'b1, RSP_WTX);
    frame(8'hc2, 8'h00, 8'h00, 1, 1'b1, 1'b1, RSP_DESEL);
    st(2'd3);
    bus(1'b1, REG_DROPS, 32'h0);
    bus(1'b0, REG_DROPS, 32'h0);
    check(rd === 32'h0, "drop clear");
    summarize;
  end
endmodule
